/* delay_timer.sv */
// One-shot down counter: pulses done_o once len_i+1 cycles after start_i (a zero len_i acts as one).
// Assumes start_i and len_i come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int unsigned W = 23
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] len_i,
  output logic              done_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_r;
  logic         done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (start_i)
    begin
      cnt_nxt = (len_i == '0) ? W'(1) : len_i;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt  = cnt_r - W'(1);
      done_nxt = (cnt_r == W'(1));
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;

endmodule
`default_nettype wire

/* fault_host.sv */
// Host model that writes the fault action byte through the strobe port.
// Assumes it shares mclk_i with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fault_host (
  input  wire logic  mclk_i,
  output logic       cfg_wr_o,
  output logic [7:0] cfg_wdata_o
);
  initial cfg_wr_o = 1'b0;
  initial cfg_wdata_o = 8'h00;
  // One-cycle strobe, data inverted once released
  task automatic write(input logic [7:0] b);
    @(posedge mclk_i);
    cfg_wr_o <= 1'b1;
    cfg_wdata_o <= b;
    @(posedge mclk_i);
    cfg_wr_o <= 1'b0;
    cfg_wdata_o <= ~b;
  endtask
endmodule
`default_nettype wire

/* fault_response_retry_logic.sv */
// Input over-voltage fault response and restart sequencer.
// Assumes fault and on/off pins are asynchronous; all else on mclk_i.
// Functional notes
// - Code 01 keeps output running for delay count times unit.
// - Code 01 fault still present at expiry follows retry field.
// - Code 10 disables output at once, then follows retry field.
// - Code 11 disables output, no restarts, until fault cleared.
// - Status bit clear, clear-faults command or reset clears a latch.
// - Off then on by pin or command, or bias loss, clears.
// - Retry field 000 makes no restart; output off until cleared.
// - Retry codes 001 to 110 allow that many restart attempts.
// - All attempts failed: output off until a clearing event.
// - Attempt starts are spaced by delay count times unit.
// - Retry 111 retries forever until commanded off.
// - Continuous retry also ends on bias loss or another shutdown.
// - Delay field gives two to the field value units, 1 to 128.
// - Unit length comes from a separate time-unit input.
// - Response 00 keeps output running; only the fault flag is set.
`timescale 1ns/1ps
`default_nettype none
module fault_response_retry_logic #(
  parameter int unsigned UNIT_W = fault_retry_pkg::UNIT_W
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              cfg_wr_i,
  input  wire logic [7:0]        cfg_wdata_i,
  input  wire logic [UNIT_W-1:0] unit_cycles_i,
  input  wire logic              fault_pin_i,
  input  wire logic              ctrl_pin_i,
  input  wire logic              operation_on_i,
  input  wire logic              status_clr_i,
  input  wire logic              clear_faults_i,
  input  wire logic              other_shutdown_i,
  output logic [7:0]             cfg_rdata_o,
  output fault_retry_pkg::fault_stat_t stat_o,
  output logic [2:0]             attempts_o
);

  localparam int unsigned DW = UNIT_W + 7;

  typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_HOLD, ST_WAIT, ST_TRY, ST_LATCH} state_t;

  fault_retry_pkg::fault_cfg_t cfg_r, cfg_nxt;
  logic [2:0] fsync_r, fsync_nxt;
  logic [2:0] csync_r, csync_nxt;
  logic       fault_r, fault_nxt;
  logic       ctrl_r, ctrl_nxt;
  state_t     state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic       flag_r, flag_nxt;
  fault_retry_pkg::fault_stat_t stat_r, stat_nxt;
  logic       tmr_start;
  logic       tmr_done;
  logic [DW-1:0] tmr_len;
  logic       run_cmd;
  logic       clr;
  logic       more;

  // Config byte register
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (cfg_wr_i)
    begin
      cfg_nxt = fault_retry_pkg::fault_cfg_t'(cfg_wdata_i);
    end
  end

  // Pin synchronisers, change accepted once stages two and three agree
  always_comb
  begin
    fsync_nxt = {fsync_r[1:0], fault_pin_i};
    csync_nxt = {csync_r[1:0], ctrl_pin_i};
    fault_nxt = (fsync_r[1] == fsync_r[2]) ? fsync_r[2] : fault_r;
    ctrl_nxt  = (csync_r[1] == csync_r[2]) ? csync_r[2] : ctrl_r;
  end

  // Delay length: unit times two to the delay code
  assign tmr_len = DW'(unit_cycles_i) << cfg_r.delay;
  assign run_cmd = ctrl_r & operation_on_i;
  assign clr     = status_clr_i | clear_faults_i;
  assign more    = (cfg_r.retries == fault_retry_pkg::RETRY_FOREVER) ||
                   (cnt_r < cfg_r.retries);

  delay_timer #(
    .W(DW)
  ) u_timer (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .start_i(tmr_start),
    .len_i  (tmr_len),
    .done_o (tmr_done)
  );

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    tmr_start = 1'b0;
    flag_nxt  = flag_r;
    if (clr)
    begin
      flag_nxt = 1'b0;
    end
    if (fault_r && state_r != ST_OFF)
    begin
      flag_nxt = 1'b1;
    end
    case (state_r)
      ST_OFF:
      begin
        if (run_cmd)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (fault_r)
        begin
          case (cfg_r.resp)
            fault_retry_pkg::RESP_IGNORE: state_nxt = ST_RUN;
            fault_retry_pkg::RESP_HOLD:
            begin
              state_nxt = ST_HOLD;
              tmr_start = 1'b1;
            end
            fault_retry_pkg::RESP_DISABLE:
            begin
              state_nxt = (cfg_r.retries == fault_retry_pkg::RETRY_NONE) ?
                          ST_LATCH : ST_WAIT;
              tmr_start = 1'b1;
            end
            default: state_nxt = ST_LATCH;
          endcase
        end
      end
      ST_HOLD:
      begin
        if (!fault_r)
        begin
          state_nxt = ST_RUN;
        end
        else if (tmr_done)
        begin
          state_nxt = (cfg_r.retries == fault_retry_pkg::RETRY_NONE) ?
                      ST_LATCH : ST_WAIT;
          tmr_start = 1'b1;
        end
      end
      ST_WAIT:
      begin
        if (tmr_done)
        begin
          state_nxt = ST_TRY;
          tmr_start = 1'b1;
          if (cnt_r != fault_retry_pkg::RETRY_FOREVER)
          begin
            cnt_nxt = cnt_r + fault_retry_pkg::CNT_ONE;
          end
        end
      end
      ST_TRY:
      begin
        if (fault_r)
        begin
          state_nxt = more ? ST_WAIT : ST_LATCH;
        end
        else if (tmr_done)
        begin
          state_nxt = ST_RUN;
          cnt_nxt   = fault_retry_pkg::CNT_ZERO;
        end
      end
      default:
      begin
        if (clr)
        begin
          state_nxt = ST_RUN;
          cnt_nxt   = fault_retry_pkg::CNT_ZERO;
        end
      end
    endcase
    if (other_shutdown_i && state_r != ST_OFF)
    begin
      state_nxt = ST_LATCH;
    end
    if (!run_cmd)
    begin
      state_nxt = ST_OFF;
      cnt_nxt   = fault_retry_pkg::CNT_ZERO;
    end
    stat_nxt.output_en  = (state_nxt == ST_RUN) || (state_nxt == ST_HOLD) ||
                          (state_nxt == ST_TRY);
    stat_nxt.fault_flag = flag_nxt;
    stat_nxt.latched    = (state_nxt == ST_LATCH);
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_r   <= fault_retry_pkg::fault_cfg_t'(fault_retry_pkg::CFG_RESET);
      fsync_r <= 3'h0;
      csync_r <= 3'h0;
      fault_r <= 1'b0;
      ctrl_r  <= 1'b0;
      state_r <= ST_OFF;
      cnt_r   <= fault_retry_pkg::CNT_ZERO;
      flag_r  <= 1'b0;
      stat_r  <= '0;
    end
    else
    begin
      cfg_r   <= cfg_nxt;
      fsync_r <= fsync_nxt;
      csync_r <= csync_nxt;
      fault_r <= fault_nxt;
      ctrl_r  <= ctrl_nxt;
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      flag_r  <= flag_nxt;
      stat_r  <= stat_nxt;
    end
  end

  assign cfg_rdata_o = cfg_r;
  assign stat_o      = stat_r;
  assign attempts_o  = cnt_r;

endmodule
`default_nettype wire

/* fault_response_retry_logic_properties.sv */
// Port checks for the fault sequencer.
// Assumes binding to fault_response_retry_logic.
`timescale 1ns/1ps
`default_nettype none
module fault_response_retry_logic_properties #(
  parameter int unsigned UNIT_W = 16
) (
  input wire logic                         mclk_i,
  input wire logic                         rstn_i,
  input wire logic                         cfg_wr_i,
  input wire logic [7:0]                   cfg_wdata_i,
  input wire logic [UNIT_W-1:0]            unit_cycles_i,
  input wire logic                         fault_pin_i,
  input wire logic                         ctrl_pin_i,
  input wire logic                         operation_on_i,
  input wire logic                         status_clr_i,
  input wire logic                         clear_faults_i,
  input wire logic                         other_shutdown_i,
  input wire logic [7:0]                   cfg_rdata_o,
  input wire fault_retry_pkg::fault_stat_t stat_o,
  input wire logic [2:0]                   attempts_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire [1:0] resp = cfg_rdata_o[7:6];
  wire [2:0] tries = cfg_rdata_o[5:3];
  cfg_echo_a: assert property (cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
    else $error("config byte not stored");
  attempt_on_a: assert property ($changed(attempts_o) && attempts_o != 3'h0 |-> stat_o.output_en)
    else $error("attempt without output");
  latch_cause_a: assert property ($rose(stat_o.latched) |-> resp == 2'h3 || tries == 3'h0 || attempts_o == tries || $past(other_shutdown_i))
    else $error("latched too early");
  forever_a: assert property ($rose(stat_o.latched) && tries == 3'h7 && resp != 2'h3 |-> $past(other_shutdown_i))
    else $error("latched in endless retry");
  clear_a: assert property (stat_o.latched && (status_clr_i || clear_faults_i) |-> ##[1:2] !stat_o.latched)
    else $error("latch not cleared");
  cmd_off_a: assert property (!operation_on_i [*2] |-> !stat_o.output_en && !stat_o.latched)
    else $error("output on while commanded off");
  fault_off_a: assert property ($rose(stat_o.fault_flag) && resp[1] |-> !stat_o.output_en)
    else $error("output kept on fault");
  ignore_a: assert property ($rose(stat_o.fault_flag) && resp == 2'h0 |-> stat_o.output_en)
    else $error("ignored fault stopped output");
endmodule
bind fault_response_retry_logic fault_response_retry_logic_properties #(.UNIT_W(UNIT_W)) i_props (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
  .unit_cycles_i(unit_cycles_i), .fault_pin_i(fault_pin_i), .ctrl_pin_i(ctrl_pin_i),
  .operation_on_i(operation_on_i), .status_clr_i(status_clr_i), .clear_faults_i(clear_faults_i),
  .other_shutdown_i(other_shutdown_i), .cfg_rdata_o(cfg_rdata_o), .stat_o(stat_o),
  .attempts_o(attempts_o));
`default_nettype wire

/* fault_response_retry_logic_test.sv */
// Self-checking bench for the fault sequencer.
// Assumes host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH %0t got %h expected %h", $time, a, e); end end
module fault_response_retry_logic_test;
  logic mclk_i = 1'b0, rstn_i = 1'b0, fault_i = 1'b0, op_i = 1'b1, clr_i = 1'b0, cf_i = 1'b0, sd_i = 1'b0;
  logic                         ctrl_p = 1'b1;
  logic [15:0]                  unit_r = 16'h0002;
  logic                         cfg_wr;
  logic [7:0]                   cfg_wd, cfg_rd;
  fault_retry_pkg::fault_stat_t stat;
  logic [2:0]                   att;
  int n_errors = 0, tests_run = 0, seed = 32'he44e_d40d, c, g, L;
  fault_host i_fault_host (.mclk_i(mclk_i), .cfg_wr_o(cfg_wr), .cfg_wdata_o(cfg_wd));
  fault_response_retry_logic i_fault_response_retry_logic (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .cfg_wr_i(cfg_wr), .cfg_wdata_i(cfg_wd), .unit_cycles_i(unit_r), .fault_pin_i(fault_i),
    .ctrl_pin_i(ctrl_p), .operation_on_i(op_i), .status_clr_i(clr_i), .clear_faults_i(cf_i),
    .other_shutdown_i(sd_i), .cfg_rdata_o(cfg_rd), .stat_o(stat), .attempts_o(att));
  initial forever #20 mclk_i = ~mclk_i;
  task automatic conclude();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One settled cycle, bounded
  task automatic step();
    @(posedge mclk_i);
    #1;
    c++;
    if (c > 5000)
    begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic run_case(input logic [1:0] r, input logic [2:0] n);
    logic [2:0] d, a;
    d = 3'($unsigned($random(seed)) % 3);
    @(posedge mclk_i) unit_r <= 16'($unsigned($random(seed)) % 4 + 1);
    #1;
    L = int'(unit_r) << d;
    i_fault_host.write({r, n, d});
    step();
    `CHK(cfg_rd, {r, n, d})
    @(posedge mclk_i) fault_i <= 1'b1;
    c = 0;
    while (stat.fault_flag !== 1'b1) step();
    c = 0;
    if (r == 2'h0) repeat (20)
    begin
      step();
      `CHK(stat.output_en, 1'b1)
    end
    if (r == 2'h1)
    begin
      while (stat.output_en === 1'b1) step();
      `CHK(c + 1 >= L, 1'b1)
    end
    if (r != 2'h0)
    begin
      a = att;
      g = -1;
      c = 0;
      while (stat.latched !== 1'b1 && c < 20 * (L + 1))
      begin
        step();
        if (g >= 0) g++;
        if (att != a)
        begin
          if (g > 0) `CHK(g, L + 1)
          g = 0;
          a = att;
        end
      end
      if (n == 3'h7 && r != 2'h3)
      begin
        `CHK(stat.latched, 1'b0)
        @(posedge mclk_i) sd_i <= 1'b1;
        step();
        step();
        `CHK(stat.output_en, 1'b0)
        sd_i <= 1'b0;
        op_i <= 1'b0;
        repeat (3) step();
        `CHK(stat.output_en, 1'b0)
        op_i <= 1'b1;
        ctrl_p <= 1'b0;
        repeat (6) step();
        `CHK(stat.output_en, 1'b0)
        ctrl_p <= 1'b1;
      end
      else
      begin
        `CHK(stat.latched, 1'b1)
        `CHK(att, (r == 2'h3) ? 3'h0 : n)
        `CHK(stat.output_en, 1'b0)
      end
    end
    @(posedge mclk_i) fault_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    clr_i <= n[0];
    cf_i <= !n[0];
    @(posedge mclk_i) clr_i <= 1'b0;
    cf_i <= 1'b0;
    step();
    `CHK(stat.latched, 1'b0)
    `CHK(att, 3'h0)
    c = 0;
    while (stat.output_en !== 1'b1) step();
    $display("case done resp %0d retries %0d", r, n);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    #1;
    `CHK(cfg_rd, fault_retry_pkg::CFG_RESET)
    @(posedge mclk_i) rstn_i <= 1'b1;
    c = 0;
    while (stat.output_en !== 1'b1) step();
    for (int i = 0; i < 8; i++) run_case(2'h2, 3'(i));
    run_case(2'h3, 3'h2);
    run_case(2'h1, 3'h3);
    run_case(2'h0, 3'h0);
    run_case(2'h1, 3'h7);
    conclude();
  end
endmodule
`default_nettype wire

/* fault_retry_pkg.sv */
// Shared types and constants for the input over-voltage fault sequencer.
// Assumes a single 25 MHz clock domain for all users.
package fault_retry_pkg;

  localparam int unsigned CLK_MHZ      = 25;
  localparam int unsigned UNIT_W       = 16;
  localparam int unsigned DELAY_W      = UNIT_W + 7;
  localparam int unsigned CNT_W        = 3;

  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_HOLD     = 2'h1;
  localparam logic [1:0] RESP_DISABLE  = 2'h2;
  localparam logic [1:0] RESP_LATCH    = 2'h3;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  localparam logic [7:0] CFG_RESET     = 8'hC0;
  localparam logic [2:0] CNT_ZERO      = 3'h0;
  localparam logic [2:0] CNT_ONE       = 3'h1;

  // Fault action byte: response [7:6], retries [5:3], delay exponent [2:0]
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } fault_cfg_t;

  typedef struct packed {
    logic output_en;
    logic fault_flag;
    logic latched;
  } fault_stat_t;

endpackage
